// ===== tgc_pkg.sv
// Purpose: shared constants and types for the timer gate control block
// Assumes: 8-bit register port, 100 MHz ref_clk
// Notes: offsets index the small local register map
package tgc_pkg;

  // register map
  localparam logic [1:0] TGC_ADDR_GCON  = 2'h0;
  localparam logic [1:0] TGC_ADDR_ISTAT = 2'h1;
  localparam logic [1:0] TGC_ADDR_IMASK = 2'h2;

  // gate control field positions
  localparam int TGC_BIT_GE   = 7;
  localparam int TGC_BIT_POL  = 6;
  localparam int TGC_BIT_TM   = 5;
  localparam int TGC_BIT_SPM  = 4;
  localparam int TGC_BIT_GO   = 3;
  localparam int TGC_BIT_VAL  = 2;
  localparam int TGC_BIT_SSHI = 1;
  localparam int TGC_BIT_SSLO = 0;

  // reset values and writable bits
  localparam logic [7:0] TGC_GCON_RESET = 8'h00;
  localparam logic [7:0] TGC_GCON_WMASK = 8'hf3;
  localparam logic [1:0] TGC_IRQ_RESET  = 2'h0;

  // gate source select codes
  localparam logic [1:0] TGC_SRC_CMP2  = 2'h3;
  localparam logic [1:0] TGC_SRC_CMP1  = 2'h2;
  localparam logic [1:0] TGC_SRC_MATCH = 2'h1;
  localparam logic [1:0] TGC_SRC_PIN   = 2'h0;

  // interrupt status bit positions
  localparam int TGC_EV_DONE = 0;
  localparam int TGC_EV_EDGE = 1;

  // input synchroniser lanes
  localparam int TGC_SYNC_W   = 3;
  localparam int TGC_LANE_PIN = 0;
  localparam int TGC_LANE_C1  = 1;
  localparam int TGC_LANE_C2  = 2;

  typedef enum logic [1:0] {
    TGC_SP_IDLE  = 2'b00,
    TGC_SP_ARMED = 2'b01,
    TGC_SP_OPEN  = 2'b11
  } tgc_sp_e;

  // timer 3/5/7 is paired with timer 4/6/8
  function automatic logic [3:0] tgc_paired_timer(input logic [3:0] num);
    tgc_paired_timer = num + 4'h1;
  endfunction

endpackage

// ===== tgc_sync.sv
// Purpose: two-flop synchroniser for asynchronous gate inputs
// Assumes: single ref_clk domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module tgc_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tgc_sync_s;

  tgc_sync_s sync_reg;
  tgc_sync_s sync_next;

  always_comb
  begin
    sync_next    = sync_reg;
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;

endmodule // tgc_sync

// ===== tgc_top.sv
// Purpose: timer gate control with source select, toggle and single pulse
// Assumes: plain register port, comparators and gate pin asynchronous
// Notes: paired timer match comes from logic on ref_clk
`timescale 1ns/1ps
// Notes on behaviour
// - gate enable ignored by count enable when timer off, still drives watchdog oscillator
// - polarity bit selects active gate level
// - toggle flip-flop flips on rising gate
// - single pulse mode takes over gate
// - acquire status high while acquisition pending
// - clearing single pulse clears acquire status
// - gate level shows gate, ignores enable
// - two-bit field picks gate source
// - gate enable turns watchdog oscillator on
// - paired timer is own number plus one
module tgc_top #(
  parameter logic [3:0] TIMER_NUM = 4'h3
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // register port
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // timer links
  input  wire logic       timer_switch_on,
  input  wire logic       paired_match,
  input  wire logic       comp1_out,
  input  wire logic       comp2_out,
  input  wire logic       gate_pin,
  output logic            count_enable,
  output logic            wdt_osc_enable,
  output logic      [3:0] paired_timer_num,
  // interrupt
  output logic            irq
);

  typedef struct packed {
    logic [7:0]      ctrl;
    tgc_pkg::tgc_sp_e sp;
    logic            tff;
    logic            act_prev;
    logic            gt_prev;
    logic            gval;
    logic [1:0]      istat;
    logic [1:0]      imask;
    logic [7:0]      rdata;
    logic            count_en;
    logic            wdt_en;
    logic            irq;
    logic [3:0]      paired;
  } tgc_state_s;

  tgc_state_s r;
  tgc_state_s n;

  logic [2:0] sync_q;
  logic       wr_gcon;
  logic       wr_istat;
  logic       wr_imask;
  logic       ge;
  logic       pol;
  logic       tm;
  logic       spm;
  logic [1:0] gss;
  logic       src;
  logic       act;
  logic       act_rise;
  logic       gate_t;
  logic       gt_rise;
  logic       gt_fall;
  logic       arm_req;
  logic       done_ev;
  logic       eff;

  // pin and comparators cross in from outside ref_clk
  tgc_sync #(
    .W (tgc_pkg::TGC_SYNC_W)
  ) tgc_sync_inst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({comp2_out, comp1_out, gate_pin}),
    .q       (sync_q)
  );

  // one decode shared by the three register strobes
  function automatic logic tgc_hit(input logic strobe, input logic [1:0] a,
                                   input logic [1:0] want);
    tgc_hit = strobe && (a == want);
  endfunction

  assign wr_gcon  = tgc_hit(wr_en, addr, tgc_pkg::TGC_ADDR_GCON);
  assign wr_istat = tgc_hit(wr_en, addr, tgc_pkg::TGC_ADDR_ISTAT);
  assign wr_imask = tgc_hit(wr_en, addr, tgc_pkg::TGC_ADDR_IMASK);

  assign ge  = r.ctrl[tgc_pkg::TGC_BIT_GE];
  assign pol = r.ctrl[tgc_pkg::TGC_BIT_POL];
  assign tm  = r.ctrl[tgc_pkg::TGC_BIT_TM];
  assign spm = r.ctrl[tgc_pkg::TGC_BIT_SPM];
  assign gss = r.ctrl[tgc_pkg::TGC_BIT_SSHI:tgc_pkg::TGC_BIT_SSLO];

  always_comb
  begin
    n = r;
    // source mux
    case (gss)
      tgc_pkg::TGC_SRC_CMP2:  src = sync_q[tgc_pkg::TGC_LANE_C2];
      tgc_pkg::TGC_SRC_CMP1:  src = sync_q[tgc_pkg::TGC_LANE_C1];
      tgc_pkg::TGC_SRC_MATCH: src = paired_match;
      default:                src = sync_q[tgc_pkg::TGC_LANE_PIN];
    endcase
    act        = pol ? src : ~src;
    act_rise   = act && !r.act_prev;
    n.act_prev = act;
    // toggle flip-flop
    if (!tm)
    begin
      n.tff = 1'b0;
    end
    else if (act_rise)
    begin
      n.tff = ~r.tff;
    end
    gate_t    = tm ? r.tff : act;
    gt_rise   = gate_t && !r.gt_prev;
    gt_fall   = !gate_t && r.gt_prev;
    n.gt_prev = gate_t;
    // single pulse sequencer; go is set-only from software
    arm_req = wr_gcon && wdata[tgc_pkg::TGC_BIT_GO] && spm;
    done_ev = 1'b0;
    case (r.sp)
      tgc_pkg::TGC_SP_IDLE:
      begin
        if (arm_req)
        begin
          n.sp = tgc_pkg::TGC_SP_ARMED;
        end
      end
      tgc_pkg::TGC_SP_ARMED:
      begin
        if (gt_rise)
        begin
          n.sp = tgc_pkg::TGC_SP_OPEN;
        end
      end
      tgc_pkg::TGC_SP_OPEN:
      begin
        if (gt_fall)
        begin
          n.sp    = tgc_pkg::TGC_SP_IDLE;
          done_ev = 1'b1;
        end
      end
      default:
      begin
        n.sp = tgc_pkg::TGC_SP_IDLE;
      end
    endcase
    if (!spm)
    begin
      n.sp    = tgc_pkg::TGC_SP_IDLE;
      done_ev = 1'b0;
    end
    // in single pulse mode only the open window passes the gate
    eff = spm ? (n.sp == tgc_pkg::TGC_SP_OPEN) : gate_t;
    // level shown regardless of gate enable
    n.gval     = eff;
    n.count_en = timer_switch_on && (!ge || eff);
    // control write; go and level bits are not stored here
    if (wr_gcon)
    begin
      n.ctrl = wdata & tgc_pkg::TGC_GCON_WMASK;
    end
    n.wdt_en = ge;
    n.paired = tgc_pkg::tgc_paired_timer(TIMER_NUM);
    // sticky events; a set in the clear cycle wins
    n.istat = r.istat & ~(wr_istat ? wdata[1:0] : 2'h0);
    n.istat[tgc_pkg::TGC_EV_DONE] = n.istat[tgc_pkg::TGC_EV_DONE] | done_ev;
    n.istat[tgc_pkg::TGC_EV_EDGE] = n.istat[tgc_pkg::TGC_EV_EDGE] | gt_rise;
    if (wr_imask)
    begin
      n.imask = wdata[1:0];
    end
    n.irq = |(n.istat & n.imask);
    // read data stands one cycle, zero otherwise
    n.rdata = 8'h00;
    if (rd_en)
    begin
      case (addr)
        tgc_pkg::TGC_ADDR_GCON:
        begin
          n.rdata = r.ctrl;
          n.rdata[tgc_pkg::TGC_BIT_GO]  = (r.sp != tgc_pkg::TGC_SP_IDLE);
          n.rdata[tgc_pkg::TGC_BIT_VAL] = r.gval;
        end
        tgc_pkg::TGC_ADDR_ISTAT: n.rdata = {6'h00, r.istat};
        tgc_pkg::TGC_ADDR_IMASK: n.rdata = {6'h00, r.imask};
        default:                 n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      r          <= '0;
      r.ctrl     <= tgc_pkg::TGC_GCON_RESET;
      r.sp       <= tgc_pkg::TGC_SP_IDLE;
      r.istat    <= tgc_pkg::TGC_IRQ_RESET;
      r.imask    <= tgc_pkg::TGC_IRQ_RESET;
      // gate reads active at power-on, so edge history starts high: no false rise
      r.act_prev <= 1'b1;
      r.gt_prev  <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign rdata            = r.rdata;
  assign count_enable     = r.count_en;
  assign wdt_osc_enable   = r.wdt_en;
  assign paired_timer_num = r.paired;
  assign irq              = r.irq;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_arm;
    wr_gcon && wdata[tgc_pkg::TGC_BIT_GO] && spm && (r.sp == tgc_pkg::TGC_SP_IDLE);
  endsequence

  sequence s_close;
    spm && (r.sp == tgc_pkg::TGC_SP_OPEN) && gt_fall;
  endsequence

  sequence s_open;
    spm && (r.sp == tgc_pkg::TGC_SP_ARMED) && gt_rise;
  endsequence

  AST_TIMER_OFF: assert property (!timer_switch_on |=> !count_enable)
    else $error("count enabled while timer off");

  AST_UNGATED: assert property (timer_switch_on && !ge |=> count_enable)
    else $error("ungated timer not counting");

  AST_POLARITY: assert property (
    timer_switch_on && ge && !tm && !spm && (src != pol) |=> !count_enable)
    else $error("counting on inactive gate level");

  AST_TOGGLE_CLR: assert property (!tm |=> !r.tff)
    else $error("toggle flop not held clear");

  AST_SPM_BLOCK: assert property (
    spm && (r.sp == tgc_pkg::TGC_SP_IDLE) && timer_switch_on && ge |=> !count_enable)
    else $error("single pulse idle but counting");

  AST_ARM: assert property (s_arm |=> (r.sp == tgc_pkg::TGC_SP_ARMED))
    else $error("arm write did not arm");

  AST_SPM_OFF: assert property (!spm |=> (r.sp == tgc_pkg::TGC_SP_IDLE))
    else $error("acquire status not cleared");

  AST_GVAL: assert property (!spm && !ge |=> (r.gval == $past(gate_t)))
    else $error("gate level wrong");

  AST_SRC_MATCH: assert property (
    (gss == tgc_pkg::TGC_SRC_MATCH) && pol |-> (act == paired_match))
    else $error("paired match not selected");

  AST_WDT: assert property (ge |=> wdt_osc_enable)
    else $error("watchdog oscillator not enabled");

  AST_PAIRED: assert property (!$past(reset) |-> paired_timer_num == TIMER_NUM + 4'h1)
    else $error("paired timer number wrong");

  AST_RESET: assert property (@(posedge ref_clk) disable iff (1'b0)
    reset |=> (r.ctrl == tgc_pkg::TGC_GCON_RESET))
    else $error("control not reset");

  AST_CLOSE: assert property (
    s_close |=> (r.sp == tgc_pkg::TGC_SP_IDLE) && r.istat[tgc_pkg::TGC_EV_DONE])
    else $error("pulse close not finished");

  AST_IRQ: assert property (irq == |(r.istat & r.imask))
    else $error("irq does not match status");

  AST_TOGGLE_FLIP: assert property (
    tm && act_rise |=> (r.tff != $past(r.tff)))
    else $error("toggle flop did not flip");

  AST_TOGGLE_GATE: assert property (
    tm && !spm && timer_switch_on && ge |=> (count_enable == $past(r.tff)))
    else $error("toggle flop not driving the gate");

  AST_OPEN: assert property (
    s_open |=> (r.sp == tgc_pkg::TGC_SP_OPEN))
    else $error("armed pulse did not open");

  AST_OPEN_COUNT: assert property (
    s_open ##0 timer_switch_on |=> count_enable)
    else $error("open pulse window not counting");

  AST_BLOCKED: assert property (
    spm && (r.sp == tgc_pkg::TGC_SP_IDLE) && !arm_req |=> (r.sp == tgc_pkg::TGC_SP_IDLE))
    else $error("pulse logic left idle without arming");

  AST_GO_READ: assert property (
    rd_en && (addr == tgc_pkg::TGC_ADDR_GCON) |=>
      (rdata[tgc_pkg::TGC_BIT_GO] == $past(r.sp != tgc_pkg::TGC_SP_IDLE)))
    else $error("acquire status read back wrong");

  AST_VAL_READ: assert property (
    rd_en && (addr == tgc_pkg::TGC_ADDR_GCON) |=>
      (rdata[tgc_pkg::TGC_BIT_VAL] == $past(r.gval)))
    else $error("gate level read back wrong");

  AST_WDT_OFF: assert property (
    !ge |=> !wdt_osc_enable)
    else $error("watchdog oscillator on without gate enable");

  AST_WRITE_MASK: assert property (
    wr_gcon |=> (r.ctrl == $past(wdata & tgc_pkg::TGC_GCON_WMASK)))
    else $error("read-only control bits were stored");

  AST_EDGE_SET: assert property (
    gt_rise |=> r.istat[tgc_pkg::TGC_EV_EDGE])
    else $error("gate rise not recorded");

  AST_DONE_CLEAR: assert property (
    wr_istat && wdata[tgc_pkg::TGC_EV_DONE] && !done_ev |=> !r.istat[tgc_pkg::TGC_EV_DONE])
    else $error("done status not cleared by write");

  AST_RDATA_IDLE: assert property (
    !rd_en |=> (rdata == 8'h00))
    else $error("read data outside its cycle");

endmodule // tgc_top

// ===== tgc_far_side.sv
// Purpose: far side model, comparators, paired match and gate pin
// Assumes: levels commanded by the bench
// Notes: registered so every edge lands just after ref_clk
`timescale 1ns/1ps
module tgc_far_side (
  // clock
  input  wire logic       ref_clk,
  // bit 0 pin, 1 match, 2 cmp1, 3 cmp2
  input  wire logic [3:0] lvl,
  // gate sources
  output logic            gate_pin,
  output logic            paired_match,
  output logic            comp1_out,
  output logic            comp2_out
);
  always_ff @(posedge ref_clk)
  begin
    {comp2_out, comp1_out, paired_match, gate_pin} <= lvl;
  end
endmodule // tgc_far_side

// ===== test_timer_gate_control.sv
// Purpose: self-checking bench for the timer gate control block
// Assumes: 100 MHz ref_clk, sync reset
// Notes: reads and probes queue notes, a monitor compares
`timescale 1ns/1ps
module test_timer_gate_control;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic       rd_q = 1'b0;
  logic       probe = 1'b0;
  logic       on = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [7:0] rdata;
  logic [3:0] ptn;
  logic       pm, c1, c2, gp, ce, wdt, irq, pol, v;
  logic [1:0] ss;
  logic [7:0] exp_q[$];
  int         mismatches = 0;
  int         checked = 0;

  always #5 ref_clk = ~ref_clk;

  tgc_top tgc_top_inst (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_switch_on(on),
    .paired_match(pm), .comp1_out(c1), .comp2_out(c2), .gate_pin(gp),
    .count_enable(ce), .wdt_osc_enable(wdt), .paired_timer_num(ptn), .irq(irq));
  tgc_far_side tgc_far_side_inst (.ref_clk(ref_clk), .lvl(lvl), .gate_pin(gp),
    .paired_match(pm), .comp1_out(c1), .comp2_out(c2));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask

  // expected {irq, wdt_osc_enable, count_enable}
  task automatic pr(input logic [2:0] e);
    exp_q.push_back({5'h00, e});
    @(posedge ref_clk);
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
  endtask

  // sync stages plus toggle and output registers
  task automatic settle();
    repeat (6) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk)
  begin
    rd_q <= rd_en;
    if (rd_q)
      check(rdata, exp_q.pop_front());
    if (probe)
      check({5'h00, irq, wdt, ce}, exp_q.pop_front());
  end

  initial
  begin
    #200us;
    mismatches++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h764233cf));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check({4'h0, ptn}, 8'h04);
    rd(2'h0, 8'h04);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h80);
    settle();
    pr(3'b010);
    // gate control written before the timer is switched on
    on <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      pol = i[2];
      ss = i[1:0];
      v = 1'($urandom % 2);
      lvl <= v ? (4'h1 << ss) : ~(4'h1 << ss);
      wr(2'h0, {1'b1, pol, 4'h0, ss});
      settle();
      pr({2'b01, v == pol});
      rd(2'h0, {1'b1, pol, 3'h0, v == pol, ss});
      wr(2'h0, {1'b0, pol, 4'h0, ss});
      settle();
      pr(3'b001);
      rd(2'h0, {1'b0, pol, 3'h0, v == pol, ss});
    end
    lvl <= 4'h0;
    // let the old source drain first, else a stale high could flip the toggle flop
    settle();
    wr(2'h0, 8'he0);
    settle();
    pr(3'b010);
    for (int i = 0; i < 2; i++)
    begin
      lvl <= 4'h1;
      settle();
      lvl <= 4'h0;
      settle();
      pr({2'b01, i == 0});
    end
    lvl <= 4'h1;
    settle();
    lvl <= 4'h0;
    settle();
    // flop is set here, leaving toggle mode must clear it
    wr(2'h0, 8'hc0);
    wr(2'h0, 8'he0);
    settle();
    pr(3'b010);
    wr(2'h1, 8'hff);
    wr(2'h2, 8'h01);
    wr(2'h0, 8'hd0);
    wr(2'h0, 8'hd8);
    settle();
    rd(2'h0, 8'hd8);
    pr(3'b010);
    lvl <= 4'h1;
    settle();
    pr(3'b011);
    lvl <= 4'h0;
    settle();
    pr(3'b110);
    rd(2'h0, 8'hd0);
    rd(2'h1, 8'h03);
    lvl <= 4'h1;
    settle();
    pr(3'b110);
    lvl <= 4'h0;
    wr(2'h2, 8'h00);
    pr(3'b010);
    wr(2'h2, 8'h01);
    pr(3'b110);
    wr(2'h1, 8'h01);
    pr(3'b010);
    wr(2'h0, 8'hd8);
    rd(2'h0, 8'hd8);
    wr(2'h0, 8'hc8);
    rd(2'h0, 8'hc0);
    settle();
    complete_run();
  end
endmodule // test_timer_gate_control
